// ---- rtl/sec_consts.vh ----
// Constants of the serial memory command front end.
`ifndef SEC_CONSTS_VH
`define SEC_CONSTS_VH
`define SEC_OP_STATUS_WRITE_CMD_CMD   8'h01
`define SEC_OP_WRITE      8'h02
`define SEC_OP_READ       8'h03
`define SEC_OP_LOCK_CMD   8'h04
`define SEC_OP_STAT_RD    8'h05
`define SEC_OP_UNLOCK_CMD 8'h06
`define SEC_ST_GUARD      7
`define SEC_ST_IDSEL      6
`define SEC_ST_IDLOCK     4
`define SEC_ST_BPH        3
`define SEC_ST_BPL        2
`define SEC_ST_LATCH      1
`define SEC_ST_BUSY       0
`define SEC_PROG_TIME_US  5000
`define SEC_CLK_MHZ       10
`define SEC_PROG_CYCLES   (`SEC_PROG_TIME_US * `SEC_CLK_MHZ)
`define SEC_FIFO_DEPTH    8
`endif

// ---- rtl/sec_fifo.v ----
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module sec_fifo #(
  parameter W = 8,
  parameter D = 8,
  parameter A = 3
) (
  input  wire         mclk_i,
  input  wire         rst_b_i,
  input  wire         clr_i,
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0] mem_r [0:D-1];
  reg [A-1:0] wp_r;
  reg [A-1:0] rp_r;
  reg [A:0]   cnt_r;
  wire        push;
  wire        pop;
  integer     i;

  assign in_ready_o  = (cnt_r != D);
  assign out_valid_o = (cnt_r != 0);
  assign out_data_o  = mem_r[rp_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wp_r  <= {A{1'b0}};
      rp_r  <= {A{1'b0}};
      cnt_r <= {(A+1){1'b0}};
      for (i = 0; i < D; i = i + 1) begin
        mem_r[i] <= {W{1'b0}};
      end
    end else if (clr_i) begin
      wp_r  <= {A{1'b0}};
      rp_r  <= {A{1'b0}};
      cnt_r <= {(A+1){1'b0}};
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data_i;
        wp_r        <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// ---- rtl/sec_spi_front.v ----
// Serial command front end with status/control register and write protection.
`timescale 1ns/1ps
`include "sec_consts.vh"
module sec_spi_front #(
  parameter PROG_CYCLES = `SEC_PROG_CYCLES
) (
  input  wire        mclk_i,
  input  wire        rst_b_i,
  input  wire        sck_i,
  input  wire        sel_b_i,
  input  wire        si_i,
  input  wire        pause_b_i,
  input  wire        protect_b_i,
  output wire        so_o,
  output wire        so_oe_b_o,
  output wire        standby_o,
  output reg         wr_valid_o,
  input  wire        wr_ready_i,
  output reg  [13:0] wr_addr_o,
  output reg  [7:0]  wr_data_o,
  output reg         wr_idpage_o,
  output reg         prog_start_o,
  output reg         rd_req_o,
  output reg  [13:0] rd_addr_o,
  output reg         rd_idpage_o,
  input  wire [7:0]  rd_data_i,
  output wire [7:0]  status_o
);
  // ------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------------
  wire [4:0] pins_s;
  // The reset image equals the idle pins, so no false clock edge follows reset.
  sec_sync #(.W(5), .RST(5'h0F)) u_sync (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({sck_i, sel_b_i, si_i, pause_b_i, protect_b_i}),
    .q_o     (pins_s)
  );
  wire sck_s   = pins_s[4];
  wire sel_b_s = pins_s[3];
  wire si_s    = pins_s[2];
  wire pause_s = ~pins_s[1];
  wire prot_b  = pins_s[0];

  reg  sck_d_r;
  reg  sel_d_r;
  wire active  = ~sel_b_s & ~pause_s;
  wire sck_up  = sck_s & ~sck_d_r & active;
  wire sck_dn  = ~sck_s & sck_d_r & active;
  wire sel_rise = sel_b_s & ~sel_d_r;

  // ------------------------------------------------------------------
  // Frame state
  // ------------------------------------------------------------------
  localparam ST_OPC  = 6'h01;
  localparam ST_ADDR = 6'h02;
  localparam ST_WDAT = 6'h04;
  localparam ST_RDAT = 6'h08;
  localparam ST_SOUT = 6'h10;
  localparam ST_IGN  = 6'h20;

  reg [5:0]  st_r;
  reg [7:0]  opc_r;
  reg [7:0]  sh_r;
  reg [3:0]  bit_r;
  reg [15:0] addr_r;
  reg [7:0]  out_r;
  reg        so_r;
  reg        wr_seen_r;
  reg        sr_pend_r;
  reg [7:0]  sr_new_r;
  reg        rw_done_r;
  reg        addr_hi_r;

  // Status bits.
  reg        guard_r;
  reg        idsel_r;
  reg        idlock_r;
  reg  [1:0] bp_r;
  reg        latch_r;
  reg        busy_r;
  reg [22:0] prog_cnt_r;

  assign status_o = {guard_r, idsel_r, 1'b0, idlock_r, bp_r, latch_r, busy_r};

  wire hw_prot = ~prot_b & guard_r;

  function blocked;
    input [1:0]  bp;
    input [13:0] a;
    begin
      case (bp)
        2'b01:   blocked = (a >= 14'h3000);
        2'b10:   blocked = (a >= 14'h2000);
        2'b11:   blocked = 1'b1;
        default: blocked = 1'b0;
      endcase
    end
  endfunction

  wire [13:0] cur_addr = idsel_r ? {8'h00, addr_r[5:0]} : addr_r[13:0];
  wire wr_ok = latch_r & ~blocked(bp_r, cur_addr) & ~(idsel_r & idlock_r);
  wire [7:0] sh_nxt = {sh_r[6:0], si_s};

  // ------------------------------------------------------------------
  // Write request buffer
  // ------------------------------------------------------------------
  // Accepted bytes queue here, up to 8 deep, so that page bytes can wait for a slow array port.
  // A byte that finds the queue full is not accepted.
  reg         push_r;
  reg  [22:0] push_data_r;
  wire        wq_in_ready;
  wire        wq_out_valid;
  wire        wq_out_ready = ~wr_valid_o | wr_ready_i;
  wire [22:0] wq_out_data;

  sec_fifo #(.W(23), .D(`SEC_FIFO_DEPTH), .A(3)) u_wbuf (
    .mclk_i      (mclk_i),
    .rst_b_i     (rst_b_i),
    .clr_i       (1'b0),
    .in_valid_i  (push_r),
    .in_ready_o  (wq_in_ready),
    .in_data_i   (push_data_r),
    .out_valid_o (wq_out_valid),
    .out_ready_i (wq_out_ready),
    .out_data_o  (wq_out_data)
  );

  // ------------------------------------------------------------------
  // Shift engine, decode and status register
  // ------------------------------------------------------------------
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sck_d_r      <= 1'b0;
      sel_d_r      <= 1'b1;
      st_r         <= ST_OPC;
      opc_r        <= 8'h00;
      sh_r         <= 8'h00;
      bit_r        <= 4'h0;
      addr_r       <= 16'h0000;
      out_r        <= 8'h00;
      so_r         <= 1'b0;
      wr_seen_r    <= 1'b0;
      sr_pend_r    <= 1'b0;
      sr_new_r     <= 8'h00;
      rw_done_r    <= 1'b0;
      guard_r      <= 1'b0;
      idsel_r      <= 1'b0;
      idlock_r     <= 1'b0;
      bp_r         <= 2'b00;
      latch_r      <= 1'b0;
      busy_r       <= 1'b0;
      prog_cnt_r   <= 23'h000000;
      wr_valid_o   <= 1'b0;
      wr_addr_o    <= 14'h0000;
      wr_data_o    <= 8'h00;
      wr_idpage_o  <= 1'b0;
      prog_start_o <= 1'b0;
      rd_req_o     <= 1'b0;
      rd_addr_o    <= 14'h0000;
      rd_idpage_o  <= 1'b0;
      push_r       <= 1'b0;
      push_data_r  <= 23'h000000;
      addr_hi_r    <= 1'b0;
    end else begin
      sck_d_r      <= sck_s;
      sel_d_r      <= sel_b_s;
      prog_start_o <= 1'b0;
      rd_req_o     <= 1'b0;
      push_r       <= 1'b0;
      if (wr_valid_o && wr_ready_i) begin
        wr_valid_o <= 1'b0;
      end
      if (wq_out_valid && wq_out_ready) begin
        wr_valid_o  <= 1'b1;
        wr_idpage_o <= wq_out_data[22];
        wr_addr_o   <= wq_out_data[21:8];
        wr_data_o   <= wq_out_data[7:0];
      end
      if (busy_r) begin
        if (prog_cnt_r == PROG_CYCLES[22:0] - 23'h1) begin
          busy_r     <= 1'b0;
          prog_cnt_r <= 23'h000000;
        end else begin
          prog_cnt_r <= prog_cnt_r + 23'h1;
        end
      end
      if (sel_b_s) begin
        st_r      <= ST_OPC;
        bit_r     <= 4'h0;
        addr_hi_r <= 1'b0;
      end
      if (sel_rise) begin
        if (rw_done_r) begin
          idsel_r <= 1'b0;
        end
        rw_done_r <= 1'b0;
        if (wr_seen_r) begin
          busy_r       <= 1'b1;
          prog_start_o <= 1'b1;
          latch_r      <= 1'b0;
          wr_seen_r    <= 1'b0;
        end
        if (sr_pend_r) begin
          sr_pend_r <= 1'b0;
          busy_r    <= 1'b1;
          latch_r   <= 1'b0;
          guard_r   <= sr_new_r[`SEC_ST_GUARD];
          bp_r      <= sr_new_r[`SEC_ST_BPH:`SEC_ST_BPL];
          if (!(sr_new_r[`SEC_ST_IDSEL] && sr_new_r[`SEC_ST_IDLOCK])) begin
            idsel_r  <= sr_new_r[`SEC_ST_IDSEL];
            idlock_r <= idlock_r | sr_new_r[`SEC_ST_IDLOCK];
          end
        end
      end
      if (sck_up) begin
        sh_r  <= sh_nxt;
        bit_r <= (bit_r == 4'h7) ? 4'h0 : bit_r + 4'h1;
        case (st_r)
          ST_OPC: begin
            if (bit_r == 4'h7) begin
              opc_r <= sh_nxt;
              st_r  <= ST_IGN;
              if (sh_nxt == `SEC_OP_STAT_RD) begin
                out_r <= status_o;
                st_r  <= ST_SOUT;
              end else if (!busy_r) begin
                case (sh_nxt)
                  `SEC_OP_UNLOCK_CMD: latch_r <= 1'b1;
                  `SEC_OP_LOCK_CMD:   latch_r <= 1'b0;
                  `SEC_OP_READ:       st_r    <= ST_ADDR;
                  `SEC_OP_WRITE:      st_r    <= latch_r ? ST_ADDR : ST_IGN;
                  `SEC_OP_STATUS_WRITE_CMD_CMD:   st_r    <= ST_WDAT;
                  default:            st_r    <= ST_IGN;
                endcase
              end
            end
          end
          ST_ADDR: begin
            addr_r <= {addr_r[14:0], si_s};
            // The address is complete when its second byte has been taken.
            if (bit_r == 4'h7) begin
              addr_hi_r <= 1'b1;
            end
            if (bit_r == 4'h7 && addr_hi_r) begin
              st_r <= (opc_r == `SEC_OP_READ) ? ST_RDAT : ST_WDAT;
            end
            if (bit_r == 4'h7 && addr_hi_r && opc_r == `SEC_OP_READ) begin
              rd_req_o    <= 1'b1;
              rd_addr_o   <= idsel_r ? {8'h00, addr_r[4:0], si_s} : {addr_r[12:0], si_s};
              rd_idpage_o <= idsel_r;
            end
          end
          ST_WDAT: begin
            if (bit_r == 4'h7) begin
              if (opc_r == `SEC_OP_STATUS_WRITE_CMD_CMD) begin
                if (latch_r && !hw_prot) begin
                  sr_pend_r <= 1'b1;
                  sr_new_r  <= sh_nxt;
                end
                st_r <= ST_IGN;
              end else begin
                if (wr_ok && wq_in_ready) begin
                  push_r      <= 1'b1;
                  push_data_r <= {idsel_r, cur_addr, sh_nxt};
                  wr_seen_r   <= 1'b1;
                  rw_done_r   <= 1'b1;
                end
                addr_r[5:0] <= addr_r[5:0] + 6'h01;
              end
            end
          end
          ST_RDAT: begin
            if (bit_r == 4'h7) begin
              rw_done_r   <= 1'b1;
              rd_req_o    <= 1'b1;
              rd_addr_o   <= idsel_r ? {8'h00, rd_addr_o[5:0] + 6'h01} : rd_addr_o + 14'h0001;
              rd_idpage_o <= idsel_r;
            end
          end
          ST_SOUT: begin
            if (bit_r == 4'h7) begin
              out_r <= status_o;
            end
          end
          default: st_r <= ST_IGN;
        endcase
      end
      if (rd_req_o) begin
        out_r <= rd_data_i;
      end
      if (sck_dn) begin
        if (st_r == ST_RDAT || st_r == ST_SOUT) begin
          so_r  <= out_r[3'h7 - bit_r[2:0]];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Output pin
  // ------------------------------------------------------------------
  assign so_o      = so_r;
  assign so_oe_b_o = ~(active & (st_r == ST_RDAT || st_r == ST_SOUT));
  assign standby_o = sel_b_s & ~busy_r;
endmodule

// ---- rtl/sec_sync.v ----
// Two flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module sec_sync #(
  parameter W   = 1,
  parameter RST = 0
) (
  input  wire         mclk_i,
  input  wire         rst_b_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;

  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_r <= RST[W-1:0];
      s2_r <= RST[W-1:0];
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end
  assign q_o = s2_r;
endmodule

// ---- verification/sec_host.sv ----
// Host serial controller model that drives the shift link in mode zero.
`timescale 1ns/1ps
module sec_host (
  input  wire mclk_i,
  input  wire so_i,
  input  wire so_oe_b_i,
  output reg  sck_o,
  output reg  sel_b_o,
  output reg  si_o,
  output reg  pause_b_o
);
  reg last_so;
  initial begin
    sck_o = 1'b0;
    sel_b_o = 1'b1;
    si_o = 1'b0;
    pause_b_o = 1'b1;
    last_so = 1'b0;
  end
  always @(posedge mclk_i) begin
    if (!so_oe_b_i)
      last_so <= so_i;
  end
  task tick(input integer n);
    repeat (n) @(posedge mclk_i);
  endtask
  task frame_on;
    sel_b_o <= 1'b0;
    tick(4);
  endtask
  task frame_off;
    sck_o <= 1'b0;
    tick(4);
    sel_b_o <= 1'b1;
    si_o    <= ~si_o;
    tick(8);
  endtask
  task xfer(input [7:0] b, input pz, output [7:0] r);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      sck_o <= 1'b0;
      si_o  <= b[i];
      tick(4);
      if (pz && i == 3) begin
        pause_b_o <= 1'b0;
        si_o      <= ~b[i];
        tick(4);
        sck_o     <= 1'b1;
        tick(4);
        sck_o     <= 1'b0;
        tick(4);
        si_o      <= b[i];
        pause_b_o <= 1'b1;
        tick(4);
      end
      r[i] = so_oe_b_i ? ~last_so : so_i;
      sck_o <= 1'b1;
      tick(4);
    end
  endtask
endmodule

// ---- verification/sec_spi_front_assertions.sv ----
// Concurrent checks on the ports of the serial command front end.
`timescale 1ns/1ps
module sec_spi_front_assertions #(
  parameter PROG_CYCLES = 50000
) (
  input wire        mclk_i,
  input wire        rst_b_i,
  input wire        sel_b_i,
  input wire        pause_b_i,
  input wire        so_oe_b_o,
  input wire        standby_o,
  input wire        wr_valid_o,
  input wire        wr_ready_i,
  input wire [13:0] wr_addr_o,
  input wire [7:0]  wr_data_o,
  input wire        wr_idpage_o,
  input wire        prog_start_o,
  input wire [7:0]  status_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  reg  [31:0] busy_cnt_r;
  wire [31:0] busy_cnt_nxt = status_o[0] ? busy_cnt_r + 32'h1 : 32'h0;
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      busy_cnt_r <= 32'h0;
    else
      busy_cnt_r <= busy_cnt_nxt;
  end
  sequence s_off_link;
    (sel_b_i || !pause_b_i) [*5];
  endsequence
  sequence s_deselected;
    sel_b_i [*5];
  endsequence
  sequence s_wr_stall;
    wr_valid_o && !wr_ready_i;
  endsequence
  a_float_off_link: assert property (s_off_link |-> so_oe_b_o)
    else $error("output driven while deselected or paused");
  a_standby_idle: assert property (standby_o |-> !status_o[0])
    else $error("standby while busy");
  a_standby_entry: assert property (s_deselected ##0 !status_o[0] |-> standby_o)
    else $error("no standby while deselected and idle");
  a_status_zero: assert property (status_o[5] == 1'b0)
    else $error("status bit five not zero");
  a_wr_held: assert property (s_wr_stall |=> wr_valid_o && $stable(wr_addr_o) && $stable(wr_data_o))
    else $error("write request dropped or changed");
  a_wr_needs_latch: assert property ($rose(wr_valid_o) |-> status_o[1])
    else $error("write request without write latch");
  a_block_guard: assert property (wr_valid_o && !wr_idpage_o |-> status_o[3:2] == 2'b00 ||
    (status_o[3:2] == 2'b01 && wr_addr_o < 14'h3000) || (status_o[3:2] == 2'b10 && wr_addr_o < 14'h2000))
    else $error("write into protected block");
  a_idpage_locked: assert property (wr_valid_o && wr_idpage_o |-> !status_o[4])
    else $error("write into locked id page");
  a_sel_lock_pair: assert property (!($rose(status_o[6]) && $rose(status_o[4])))
    else $error("select and lock set together");
  a_prog_sets_busy: assert property (prog_start_o |-> ##[0:2] status_o[0] ##1 !prog_start_o)
    else $error("program start without busy");
  a_busy_bounded: assert property (busy_cnt_r <= PROG_CYCLES + 8)
    else $error("internal write too long");
endmodule
bind sec_spi_front sec_spi_front_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.mclk_i, .rst_b_i, .sel_b_i,
  .pause_b_i, .so_oe_b_o, .standby_o, .wr_valid_o, .wr_ready_i, .wr_addr_o, .wr_data_o, .wr_idpage_o,
  .prog_start_o, .status_o);

// ---- verification/spi_eeprom_cmd_status_protect_test.sv ----
// Self-checking bench for the serial command front end.
`timescale 1ns/1ps
module spi_eeprom_cmd_status_protect_test;
  localparam PROG = 400;
  reg         mclk_i = 1'b0;
  reg         rst_b_i = 1'b0;
  reg         protect_b = 1'b1;
  reg         wr_ready = 1'b0;
  reg  [7:0]  rd_data = 8'hC3;
  wire        sck, sel_b, si, pause_b, so, so_oe_b, wr_valid, idp_w, rd_req, idp_r;
  wire [13:0] wa, ra;
  wire [7:0]  wd;
  integer     num_errors = 0;
  integer     samples_checked = 0;
  integer     nwr = 0;
  integer     i;
  reg  [15:0] cap_w;
  reg  [15:0] cap_r = 16'hFFFF;
  reg  [7:0]  cap_d, s;
  reg  [24:0] rows [0:10];
  always #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    wr_ready <= ~wr_ready;
    if (rd_req && cap_r == 16'hFFFF)
      cap_r <= {1'b0, idp_r, ra};
    if (wr_valid && wr_ready) begin
      nwr   <= nwr + 1;
      cap_w <= {2'b00, wa};
      cap_d <= wd;
    end
  end
  sec_host h (.mclk_i(mclk_i), .so_i(so), .so_oe_b_i(so_oe_b), .sck_o(sck), .sel_b_o(sel_b), .si_o(si),
    .pause_b_o(pause_b));
  sec_spi_front #(.PROG_CYCLES(PROG)) uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .sck_i(sck), .sel_b_i(sel_b),
    .si_i(si), .pause_b_i(pause_b), .protect_b_i(protect_b), .so_o(so), .so_oe_b_o(so_oe_b), .standby_o(),
    .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_addr_o(wa), .wr_data_o(wd), .wr_idpage_o(idp_w),
    .prog_start_o(), .rd_req_o(rd_req), .rd_addr_o(ra), .rd_idpage_o(idp_r), .rd_data_i(rd_data), .status_o());
  task chk(input [15:0] seen, input [15:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task txn(input [7:0] op, input integer n, input [23:0] a, input pz, output [7:0] r);
    integer k;
    h.frame_on;
    h.xfer(op, 1'b0, r);
    for (k = n - 1; k >= 0; k = k - 1)
      h.xfer(a[k*8 +: 8], pz && k == 0, r);
    h.frame_off;
  endtask
  task settle(output [7:0] r);
    integer t;
    t = 0;
    r = 8'h01;
    while (r[0] !== 1'b0 && t < 20) begin
      txn(8'h05, 1, 24'h0, 1'b0, r);
      t = t + 1;
    end
  endtask
  task conclude;
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #3000000;
    num_errors = num_errors + 1;
    conclude;
  end
  initial begin
    rows[0] = 25'h1060002;
    rows[1] = 25'h1040000;
    rows[2] = 25'h1018C00;
    rows[3] = 25'h1A50000;
    rows[4] = 25'h1060002;
    rows[5] = 25'h1018C8C;
    rows[6] = 25'h106008E;
    rows[7] = 25'h001008E;
    rows[8] = 25'h1015000;
    rows[9] = 25'h1060002;
    rows[10] = 25'h1014444;
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    txn(8'h05, 1, 24'h0, 1'b0, s);
    chk(s, 8'h00);
    for (i = 0; i < 11; i = i + 1) begin
      protect_b <= rows[i][24];
      txn(rows[i][23:16], rows[i][23:16] == 8'h01, {16'h0, rows[i][15:8]}, 1'b0, s);
      settle(s);
      chk(s, rows[i][7:0]);
      $display("row %0d done", i);
    end
    txn(8'h03, 3, 24'h001000, 1'b1, s);
    chk(s, 8'hC3);
    chk(cap_r, 16'h4010);
    settle(s);
    chk(s, 8'h04);
    $display("id page read done");
    txn(8'h06, 0, 24'h0, 1'b0, s);
    txn(8'h02, 3, 24'h30005A, 1'b0, s);
    settle(s);
    chk(nwr[15:0], 16'h0);
    txn(8'h06, 0, 24'h0, 1'b0, s);
    txn(8'h02, 3, 24'h2FFFA5, 1'b0, s);
    txn(8'h05, 1, 24'h0, 1'b0, s);
    chk(s[0], 1'b1);
    txn(8'h06, 0, 24'h0, 1'b0, s);
    txn(8'h01, 1, 24'h000008, 1'b0, s);
    settle(s);
    chk(s, 8'h04);
    chk(cap_w, 16'h2FFF);
    chk(cap_d, 8'hA5);
    $display("array write done");
    conclude;
  end
endmodule
